//--- src/uie_gate.sv
// interrupt source enable and gating of an asynchronous serial port
// assumes pending flags come from logic on ref_clk; the
// clear-to-send pin is asynchronous and is synchronised here
`include "uie_consts.svh"

module uie_gate (
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-source pending flags
  input wire logic rxDataAvail,
  input wire logic rxCharTimeout,
  input wire logic txHoldingEmpty,
  input wire logic [3:0] lineErrSet,
  input wire logic [2:0] modemDelta,
  input wire logic clearToSendInput,
  input wire logic autobaudDone,
  input wire logic autobaudTimeout,
  // results
  output logic irq,
  output logic [3:0] irqIdent,
  output logic [7:0] divisorHigh,
  output logic divisorLatchSelect,
  output logic autoCtsEnable
);

  // ==========================================
  // state
  uie_pkg::uie_state_s q_q; // registered state
  uie_pkg::uie_state_s q_d; // next state

  // bus phase decode
  logic setupPh;   // first cycle of a transfer
  logic accessPh;  // cycle in which the transfer completes
  logic hitIer;    // address of the shared enable word
  logic hitIir;    // identification word
  logic hitLsr;    // line status word
  logic hitMsr;    // modem status word
  logic hitCtrl;   // control word
  logic mapped;    // any known address

  // gated source terms
  logic ctsEdge;     // synchronised clear-to-send change
  logic ctsIrq;      // cts change allowed to interrupt
  logic modemPend;   // modem source pending
  logic enRls;       // line status enabled and pending
  logic enRda;       // data available enabled and pending
  logic enCti;       // time-out enabled and pending
  logic enThre;      // holding empty enabled and pending
  logic enModem;     // modem enabled and pending
  logic enAbeo;      // end of auto-baud enabled
  logic enAbto;      // auto-baud time-out enabled
  logic [3:0] ident; // encoded highest source
  logic [7:0] lsrVal;// line status word
  logic [3:0] msrVal;// modem change bits

  // ==========================================
  // address decode
  // full address compare, so aliases of the window answer as errors
  always_comb
  begin
    setupPh = psel & ~penable;
    accessPh = psel & penable;
    hitIer = (paddr == `UIE_ADDR_IER);
    hitIir = (paddr == `UIE_ADDR_IIR);
    hitLsr = (paddr == `UIE_ADDR_LSR);
    hitMsr = (paddr == `UIE_ADDR_MSR);
    hitCtrl = (paddr == `UIE_ADDR_CTRL);
    mapped = hitIer | hitIir | hitLsr | hitMsr | hitCtrl;
  end

  // ==========================================
  // source gating
  // the raw conditions other than time-out and auto-baud stay visible in the status words below,
  // only the request and the identification are gated
  always_comb
  begin
    // edge seen only after both synchroniser stages
    ctsEdge = q_q.ctsSync[1] ^ q_q.ctsPrev;
    if (q_q.ctrl[`UIE_CTRL_AUTOCTS])
    begin
      ctsIrq = q_q.ctsDelta & q_q.ier[`UIE_IER_CTS];
    end
    // otherwise bit 7 plays no part
    else
    begin
      ctsIrq = q_q.ctsDelta;
    end
    modemPend = ctsIrq | (|modemDelta);
    enModem = modemPend & q_q.ier[`UIE_IER_MODEM];
    // one bit for both receive sources
    enRda = rxDataAvail & q_q.ier[`UIE_IER_RDA];
    enCti = rxCharTimeout & q_q.ier[`UIE_IER_RDA];
    enThre = txHoldingEmpty & q_q.ier[`UIE_IER_TX_HOLDING_EMPTY];
    enRls = q_q.rlsPend & q_q.ier[`UIE_IER_RLS];
    // end of auto-baud behind bit 8
    enAbeo = autobaudDone & q_q.ier[`UIE_IER_ABEO];
    enAbto = autobaudTimeout & q_q.ier[`UIE_IER_ABTO];
  end

  // ==========================================
  // priority encoder
  // receive data wins over time-out when both share the level
  always_comb
  begin
    if (enRls)
    begin
      ident = `UIE_ID_RLS;
    end
    else if (enRda)
    begin
      ident = `UIE_ID_RDA;
    end
    else if (enCti)
    begin
      ident = `UIE_ID_CTI;
    end
    else if (enThre)
    begin
      ident = `UIE_ID_TX_HOLDING_EMPTY;
    end
    else if (enModem)
    begin
      ident = `UIE_ID_MODEM;
    end
    // no source with an identification code pending
    else
    begin
      ident = `UIE_ID_NONE;
    end
  end

  // ==========================================
  // status words
  always_comb
  begin
    lsrVal = 8'h00;
    lsrVal[0] = rxDataAvail;
    lsrVal[4:1] = q_q.lsrErr;
    lsrVal[`UIE_LSR_TX_HOLDING_EMPTY] = txHoldingEmpty;
    // cts change in bit 0, others above
    msrVal = {modemDelta, q_q.ctsDelta};
  end

  // ==========================================
  // next state
  always_comb
  begin
    q_d = q_q;
    // two stages before anything reads the pin
    q_d.ctsSync = {q_q.ctsSync[0], clearToSendInput};
    q_d.ctsPrev = q_q.ctsSync[1];

    // read data is prepared in setup, held through access
    if (setupPh & ~pwrite)
    begin
      q_d.rdata = 32'h0000_0000;
      if (hitIer)
      begin
        // latch select picks the divisor byte
        if (q_q.ctrl[`UIE_CTRL_DLS])
        begin
          q_d.rdata[7:0] = q_q.dlm;
        end
        // enable word when latch select clear
        else
        begin
          q_d.rdata[9:0] = q_q.ier;
        end
      end
      else if (hitIir)
      begin
        q_d.rdata[3:0] = ident;
        q_d.rdata[`UIE_IIR_ABEO] = enAbeo;
        q_d.rdata[`UIE_IIR_ABTO] = enAbto;
      end
      else if (hitLsr)
      begin
        q_d.rdata[7:0] = lsrVal;
      end
      else if (hitMsr)
      begin
        q_d.rdata[3:0] = msrVal;
      end
      else if (hitCtrl)
      begin
        q_d.rdata[1:0] = q_q.ctrl;
      end
    end

    // writes take effect at the completing edge only
    if (accessPh & pwrite)
    begin
      if (hitIer)
      begin
        // divisor high byte while latch select set
        if (q_q.ctrl[`UIE_CTRL_DLS])
        begin
          q_d.dlm = pwdata[7:0];
        end
        else
        begin
          q_d.ier = pwdata[9:0] & `UIE_IER_MASK;
        end
      end
      else if (hitCtrl)
      begin
        q_d.ctrl = pwdata[1:0];
      end
    end

    // read side effects, clear first so a set below wins
    if (accessPh & ~pwrite)
    begin
      if (hitLsr)
      begin
        q_d.rlsPend = 1'b0;
        q_d.lsrErr = 4'h0;
      end
      // modem status read consumes the cts change
      if (hitMsr)
      begin
        q_d.ctsDelta = 1'b0;
      end
    end

    // event sets, winning over a clear in the same cycle
    if (|lineErrSet)
    begin
      q_d.lsrErr = q_d.lsrErr | lineErrSet;
      q_d.rlsPend = 1'b1;
    end
    if (ctsEdge)
    begin
      q_d.ctsDelta = 1'b1;
    end
  end

  // ==========================================
  // state register
  // every enable bit clears on reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      q_q <= '0;
      q_q.ier <= `UIE_IER_RESET;
      q_q.dlm <= `UIE_DLM_RESET;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  // ==========================================
  // outputs
  // the request is a level straight from the gated terms so it
  // drops in the cycle the enable or flag goes away
  always_comb
  begin
    prdata = q_q.rdata;
    // zero wait states, errors only for unknown addresses
    pready = accessPh;
    pslverr = accessPh & ~mapped;
    irq = enRls | enRda | enCti | enThre | enModem | enAbeo | enAbto;
    irqIdent = ident;
    divisorHigh = q_q.dlm;
    divisorLatchSelect = q_q.ctrl[`UIE_CTRL_DLS];
    autoCtsEnable = q_q.ctrl[`UIE_CTRL_AUTOCTS];
  end

endmodule

//--- src/uie_consts.svh
// addresses, field positions and reset values of the interrupt enable block
// assumes an apb slave decoding full 32-bit byte addresses
`ifndef UIE_CONSTS_SVH
`define UIE_CONSTS_SVH
// ==========================================
// register byte addresses
`define UIE_ADDR_IER 32'hE001_0004
`define UIE_ADDR_IIR 32'hE001_0008
`define UIE_ADDR_LSR 32'hE001_0014
`define UIE_ADDR_MSR 32'hE001_0018
`define UIE_ADDR_CTRL 32'hE001_0040
// ==========================================
// enable register bit positions
`define UIE_IER_RDA 0
`define UIE_IER_TX_HOLDING_EMPTY 1
`define UIE_IER_RLS 2
`define UIE_IER_MODEM 3
`define UIE_IER_CTS 7
`define UIE_IER_ABEO 8
`define UIE_IER_ABTO 9
// implemented enable bits, reserved ones never store
`define UIE_IER_MASK 10'h38F
`define UIE_IER_RESET 10'h000
`define UIE_DLM_RESET 8'h00
// ==========================================
// control register and status fields
`define UIE_CTRL_DLS 0
`define UIE_CTRL_AUTOCTS 1
`define UIE_LSR_TX_HOLDING_EMPTY 5
`define UIE_IIR_ABEO 8
`define UIE_IIR_ABTO 9
// ==========================================
// identification codes, bit 0 active low pending
`define UIE_ID_NONE 4'h1
`define UIE_ID_RLS 4'h6
`define UIE_ID_RDA 4'h4
`define UIE_ID_CTI 4'hC
`define UIE_ID_TX_HOLDING_EMPTY 4'h2
`define UIE_ID_MODEM 4'h0
`endif

//--- src/uie_pkg.sv
// types shared by the interrupt enable block
// assumes uie_consts.svh for all numeric values
package uie_pkg;
  // ==========================================
  // register field types
  typedef logic [9:0] uie_ier_t;
  typedef logic [3:0] uie_id_t;
  // ==========================================
  // whole state of the block in one word
  typedef struct packed {
    uie_ier_t ier;       // enable bits
    logic [7:0] dlm;     // divisor high byte
    logic [1:0] ctrl;    // latch select, auto flow control
    logic [1:0] ctsSync; // pin synchroniser
    logic ctsPrev;       // last synchronised level
    logic ctsDelta;      // sticky transition flag
    logic [3:0] lsrErr;  // sticky receive errors
    logic rlsPend;       // line status pending
    logic [31:0] rdata;  // read data for access phase
  } uie_state_s;
endpackage

//--- bench/uie_gate_props.sv
// checker for the interrupt enable block, ports only
// assumes the design's apb slave is zero wait state
`include "uie_consts.svh"

module uie_gate_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxDataAvail,
  input wire logic txHoldingEmpty,
  input wire logic autobaudDone,
  input wire logic autobaudTimeout,
  input wire logic irq,
  input wire logic [3:0] irqIdent,
  input wire logic [7:0] divisorHigh,
  input wire logic divisorLatchSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // shadow of the enable bits
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wrAcc;
  logic [9:0] ierSh_q;
  assign wrAcc = psel && penable && pwrite;
  // shadow follows apb writes so gating can be judged at the pins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ierSh_q <= 10'h000;
    else if (wrAcc && paddr == `UIE_ADDR_IER && !divisorLatchSelect)
      ierSh_q <= pwdata[9:0] & `UIE_IER_MASK;
  end
  // ==========================================
  // assertions
  chk_ready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_divisor_write: assert property (wrAcc && paddr == `UIE_ADDR_IER && divisorLatchSelect
    |=> divisorHigh == $past(pwdata[7:0])) else $error("divisor high byte not written");
  chk_divisor_hold: assert property (wrAcc && !divisorLatchSelect |=> $stable(divisorHigh))
    else $error("divisor changed while latch select clear");
  chk_rda_gate: assert property (rxDataAvail && ierSh_q[0] |-> irq)
    else $error("data available not raising request");
  chk_tx_holding_empty_gate: assert property (txHoldingEmpty && ierSh_q[1] |-> irq)
    else $error("holding empty not raising request");
  chk_abeo_gate: assert property (autobaudDone && ierSh_q[8] |-> irq)
    else $error("auto-baud end not raising request");
  chk_abto_gate: assert property (autobaudTimeout && ierSh_q[9] |-> irq)
    else $error("auto-baud time-out not raising request");
  chk_irq_enabled: assert property (irq |-> ierSh_q != 10'h000)
    else $error("request with every source disabled");
  chk_rls_enabled: assert property (irqIdent == `UIE_ID_RLS |-> ierSh_q[2])
    else $error("line status reported while disabled");
  // ==========================================
  // coverage of main scenarios
  cover property (irq && irqIdent == `UIE_ID_RLS);
  cover property (wrAcc && divisorLatchSelect);
  cover property (pslverr);
endmodule

bind uie_gate uie_gate_props i_uie_gate_props (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .pslverr, .rxDataAvail, .txHoldingEmpty, .autobaudDone, .autobaudTimeout, .irq,
  .irqIdent, .divisorHigh, .divisorLatchSelect);

//--- bench/uie_gate_tb.sv
// self-checking bench for the interrupt enable block
// assumes uie_gate and its bound checker are compiled first
`include "uie_consts.svh"

module uie_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cts = 0, pready, pslverr, irq, dls, acts, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0] irqIdent, lineErrSet = 0;
  logic [7:0] divisorHigh;
  logic [2:0] md = 0; // modem change flags, owned outside the block
  logic [4:0] src = 0; // data, time-out, empty, baud end, baud time-out
  int bad_count = 0, check_count = 0;
  int bitOf[5] = '{0, 0, 1, 8, 9};
  logic [3:0] idOf[3] = '{`UIE_ID_RDA, `UIE_ID_CTI, `UIE_ID_TX_HOLDING_EMPTY};
  uie_gate i_uie_gate (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxDataAvail(src[0]), .rxCharTimeout(src[1]), .txHoldingEmpty(src[2]), .lineErrSet(lineErrSet),
    .modemDelta(md), .clearToSendInput(cts), .autobaudDone(src[3]), .autobaudTimeout(src[4]),
    .irq(irq), .irqIdent(irqIdent), .divisorHigh(divisorHigh), .divisorLatchSelect(dls), .autoCtsEnable(acts));
  // ==========================================
  // clock, tasks
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer after an idle cycle, answer taken at the ready edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================
  // watchdog and tests
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, `UIE_ADDR_IER, 0);
    chk("ier reset", rd, 32'h0000_0000);
    chk("ident idle", 32'(irqIdent), 32'h0000_0001);
    // reserved bits are kept zero by software
    apb(1, `UIE_ADDR_IER, 32'h0000_038F);
    apb(0, `UIE_ADDR_IER, 0);
    chk("ier stored", rd, 32'h0000_038F);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, `UIE_ADDR_IER, 0);
      src <= 5'(1 << i);
      @(posedge ref_clk);
      chk("irq off", 32'(irq), 0);
      apb(1, `UIE_ADDR_IER, 32'(1 << bitOf[i]));
      @(posedge ref_clk);
      chk("irq on", 32'(irq), 1);
      if (i < 3)
        chk("ident", 32'(irqIdent), 32'(idOf[i]));
      src <= 5'h00;
    end
    apb(1, `UIE_ADDR_IER, 32'h0000_0005);
    src <= 5'h01;
    lineErrSet <= 4'h5;
    @(posedge ref_clk);
    lineErrSet <= 4'h0;
    @(posedge ref_clk);
    chk("ident rls", 32'(irqIdent), 32'(`UIE_ID_RLS));
    apb(0, `UIE_ADDR_LSR, 0);
    chk("lsr", rd, 32'h0000_000B);
    @(posedge ref_clk);
    chk("ident after lsr", 32'(irqIdent), 32'(`UIE_ID_RDA));
    src <= 5'h00;
    apb(1, `UIE_ADDR_CTRL, 32'h0000_0001);
    apb(1, `UIE_ADDR_IER, 32'h0000_00A5);
    // register outputs settle only after the completing edge
    @(posedge ref_clk);
    chk("divisor", 32'(divisorHigh), 32'h0000_00A5);
    chk("latch select", 32'(dls), 1);
    apb(0, `UIE_ADDR_IER, 0);
    chk("divisor read", rd, 32'h0000_00A5);
    apb(1, `UIE_ADDR_CTRL, 32'h0000_0002);
    apb(0, `UIE_ADDR_IER, 0);
    chk("ier kept", rd, 32'h0000_0005);
    chk("auto cts", 32'(acts), 1);
    apb(1, `UIE_ADDR_IER, 32'h0000_0008);
    cts <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk("cts auto bit7 off", 32'(irq), 0);
    apb(1, `UIE_ADDR_IER, 32'h0000_0088);
    @(posedge ref_clk);
    chk("cts auto bit7 on", 32'(irq), 1);
    apb(0, `UIE_ADDR_MSR, 0);
    chk("msr", rd, 32'h0000_0001);
    apb(1, `UIE_ADDR_CTRL, 0);
    apb(1, `UIE_ADDR_IER, 32'h0000_0008);
    cts <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("cts normal", 32'(irq), 1);
    // modem change flags stay readable while the source is disabled
    apb(1, `UIE_ADDR_IER, 0);
    md <= 3'b101;
    @(posedge ref_clk);
    chk("modem off", 32'(irq), 0);
    apb(0, `UIE_ADDR_MSR, 0);
    chk("msr disabled", rd, 32'h0000_000B);
    apb(1, `UIE_ADDR_IER, 32'h0000_0008);
    @(posedge ref_clk);
    chk("modem on", 32'(irq), 1);
    chk("ident modem", 32'(irqIdent), 32'(`UIE_ID_MODEM));
    // line errors and holding empty readable with their enables clear
    md <= 3'b000;
    src <= 5'h04;
    lineErrSet <= 4'h2;
    @(posedge ref_clk);
    lineErrSet <= 4'h0;
    @(posedge ref_clk);
    chk("rls gated", 32'(irq), 0);
    apb(0, `UIE_ADDR_LSR, 0);
    chk("lsr disabled", rd, 32'h0000_0024);
    chk("lsr empty bit", 32'(rd[5]), 1);
    src <= 5'h00;
    apb(1, 32'hE001_0080, 32'h0000_0001);
    chk("unmapped", 32'(er), 1);
    // second reset in mid-run with the modem source enabled and pending
    md <= 3'b001;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("irq after reset", 32'(irq), 0);
    chk("divisor after reset", 32'(divisorHigh), 0);
    apb(0, `UIE_ADDR_IER, 0);
    chk("ier after reset", rd, 32'h0000_0000);
    close_out();
  end
endmodule
